// ===== design/lvd_host_pkg.sv
package lvd_host_pkg;
	// Device register map, reached through the device's byte port
	localparam logic [15:0] DET_CONTROL_ADDR = 16'hFFBE;
	localparam logic [15:0] DET_LEVEL_ADDR = 16'hFFBF;
	localparam logic [15:0] IRQ_REQUEST_LOW_ADDR = 16'hFFE0;
	localparam logic [15:0] IRQ_MASK_LOW_ADDR = 16'hFFE4;
	localparam logic [15:0] RESET_CAUSE_ADDR = 16'hFFAC;
	// Field positions in the detection control byte
	localparam int DETECT_ENABLE_BIT = 7;
	localparam int REFERENCE_ENABLE_BIT = 4;
	localparam int RESET_MODE_BIT = 1;
	localparam int BELOW_FLAG_BIT = 0;
	// Low-supply bits in the interrupt request, mask and reset cause bytes
	localparam int IRQ_PENDING_BIT = 0;
	localparam int IRQ_MASK_BIT = 0;
	localparam int RESET_CAUSE_BIT = 0;
	// Byte values written to the device
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] CTRL_REF_ON = 8'h10;
	localparam logic [7:0] CTRL_DET_ON = 8'h90;
	localparam logic [7:0] CTRL_RESET_MODE = 8'h92;
	localparam logic [7:0] MASK_SET = 8'h01;
	localparam logic [2:0] LEVEL_RESET = 3'h0;
	// Power-on-clear option codes, and the level codes that the high and low options block
	localparam logic [1:0] CLEAR_OPT_NONE = 2'h0;
	localparam logic [1:0] CLEAR_OPT_LOW = 2'h1;
	localparam logic [1:0] CLEAR_OPT_HIGH = 2'h2;
	localparam logic [2:0] LEVEL_FIRST_BLOCKED_HIGH = 3'h4;
	localparam logic [2:0] LEVEL_BLOCKED_LOW = 3'h7;
	// Waits; least times, so the cycle counts round up
	localparam int CLK_PERIOD_NS = 10;
	localparam int REF_WAIT_US = 2000;
	localparam int DET_WAIT_US = 200;
	localparam int REF_WAIT_CYCLES = (REF_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DET_WAIT_CYCLES = (DET_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAIT_CNT_W = 18;
	// Own command port map
	localparam logic [3:0] HOST_CMD_ADDR = 4'h0;
	localparam logic [3:0] HOST_CFG_ADDR = 4'h1;
	localparam logic [3:0] HOST_LEVEL_ADDR = 4'h2;
	localparam logic [3:0] HOST_STATUS_ADDR = 4'h3;
	localparam logic [3:0] HOST_CAUSE_ADDR = 4'h4;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_STOP_BIT = 1;
	localparam int CMD_CAUSE_BIT = 3;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h00, ST_MASK = 5'h01, ST_LEVEL = 5'h02, ST_REF_ON = 5'h03,
		ST_REF_WAIT = 5'h04, ST_DET_ON = 5'h05, ST_DET_WAIT = 5'h06, ST_CHECK = 5'h07,
		ST_SET_MODE = 5'h08, ST_CLR_PEND = 5'h09, ST_UNMASK = 5'h0A, ST_RUN = 5'h0B,
		ST_STOP = 5'h0C, ST_SVC_READ = 5'h0D, ST_SVC_WAIT = 5'h0E, ST_SVC_CLR = 5'h0F,
		ST_CAUSE = 5'h10
	} seq_state_t;

	typedef enum logic [1:0] {
		PH_IDLE = 2'h0, PH_STROBE = 2'h1, PH_SAMPLE = 2'h2, PH_DONE = 2'h3
	} port_phase_t;
endpackage

// ===== design/dev_access_if.sv
`timescale 1ns/1ps
interface dev_access_if;
	logic req;
	logic we;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic ready;
	logic done;
	logic [7:0] rdata;

	modport master (output req, output we, output addr, output wdata,
		input ready, input done, input rdata);
	modport engine (input req, input we, input addr, input wdata,
		output ready, output done, output rdata);
endinterface

// ===== design/device_byte_port.sv
`timescale 1ns/1ps
module device_byte_port (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	dev_access_if.engine acc,
	output logic [15:0] o_dev_addr,
	output logic [7:0] o_dev_wdata,
	output logic o_dev_wr,
	output logic o_dev_rd,
	input wire logic [7:0] i_dev_rdata
);
	lvd_host_pkg::port_phase_t phase_reg, phase_next;
	logic [15:0] addr_reg, addr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic we_reg, we_next;
	logic [7:0] rdata_reg, rdata_next;

	// Every access is a whole byte; no bit operations exist on this port
	always_comb begin
		phase_next = phase_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		we_next = we_reg;
		rdata_next = rdata_reg;
		case (phase_reg)
			lvd_host_pkg::PH_IDLE: begin
				if (acc.req) begin
					addr_next = acc.addr;
					wdata_next = acc.wdata;
					we_next = acc.we;
					phase_next = lvd_host_pkg::PH_STROBE;
				end
			end
			lvd_host_pkg::PH_STROBE: phase_next = lvd_host_pkg::PH_SAMPLE;
			lvd_host_pkg::PH_SAMPLE: begin
				// Read data of the device stand one cycle after its strobe
				if (!we_reg) begin
					rdata_next = i_dev_rdata;
				end
				phase_next = lvd_host_pkg::PH_DONE;
			end
			default: phase_next = lvd_host_pkg::PH_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			phase_reg <= lvd_host_pkg::PH_IDLE;
			addr_reg <= 16'h0000;
			wdata_reg <= 8'h00;
			we_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			phase_reg <= phase_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			we_reg <= we_next;
			rdata_reg <= rdata_next;
		end
	end

	// Strobes stand for exactly the one strobe cycle
	assign o_dev_wr = (phase_reg == lvd_host_pkg::PH_STROBE) && we_reg;
	assign o_dev_rd = (phase_reg == lvd_host_pkg::PH_STROBE) && !we_reg;
	assign o_dev_addr = addr_reg;
	assign o_dev_wdata = wdata_reg;
	assign acc.ready = (phase_reg == lvd_host_pkg::PH_IDLE);
	assign acc.done = (phase_reg == lvd_host_pkg::PH_DONE);
	assign acc.rdata = rdata_reg;
endmodule

// ===== design/low_voltage_detect_control.sv
`timescale 1ns/1ps
module low_voltage_detect_control #(
	parameter int REF_WAIT_CYCLES = lvd_host_pkg::REF_WAIT_CYCLES,
	parameter int DET_WAIT_CYCLES = lvd_host_pkg::DET_WAIT_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic [15:0] o_dev_addr,
	output logic [7:0] o_dev_wdata,
	output logic o_dev_wr,
	output logic o_dev_rd,
	input wire logic [7:0] i_dev_rdata,
	input wire logic i_low_supply_irq,
	output logic o_vectored_irq_enable,
	output logic o_busy
);
	localparam logic [lvd_host_pkg::WAIT_CNT_W-1:0] REF_LOAD =
		lvd_host_pkg::WAIT_CNT_W'(REF_WAIT_CYCLES - 1);
	localparam logic [lvd_host_pkg::WAIT_CNT_W-1:0] DET_LOAD =
		lvd_host_pkg::WAIT_CNT_W'(DET_WAIT_CYCLES - 1);

	dev_access_if acc ();
	lvd_host_pkg::seq_state_t state_reg, state_next;
	logic pending_reg, pending_next;
	logic [lvd_host_pkg::WAIT_CNT_W-1:0] cnt_reg, cnt_next;
	logic irq_en_reg, irq_en_next;
	logic refused_reg, refused_next;
	logic flag_reg, flag_next;
	logic mask_done_reg, mask_done_next;
	logic run_mode_reg, run_mode_next;
	logic [7:0] cause_reg, cause_next;
	logic [7:0] cfg_reg, cfg_next;
	logic [2:0] level_reg, level_next;
	logic [7:0] rdata_reg, rdata_next;
	logic start_cmd, stop_cmd, cause_cmd;
	logic level_ok, clear_present, access_state, acc_we;
	logic [15:0] acc_addr;
	logic [7:0] acc_wdata;

	// Decides whether a level code is legal for the power-on-clear option
	function automatic logic level_allowed(input logic [1:0] opt, input logic [2:0] code);
		if (opt == lvd_host_pkg::CLEAR_OPT_HIGH) begin
			return code < lvd_host_pkg::LEVEL_FIRST_BLOCKED_HIGH;
		end
		if (opt == lvd_host_pkg::CLEAR_OPT_LOW) begin
			return code != lvd_host_pkg::LEVEL_BLOCKED_LOW;
		end
		return 1'b1;
	endfunction

	device_byte_port u_port (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.acc(acc.engine),
		.o_dev_addr(o_dev_addr),
		.o_dev_wdata(o_dev_wdata),
		.o_dev_wr(o_dev_wr),
		.o_dev_rd(o_dev_rd),
		.i_dev_rdata(i_dev_rdata)
	);

	// Command pulses come straight from writes to the command address
	assign start_cmd = i_wr && i_addr == lvd_host_pkg::HOST_CMD_ADDR &&
		i_wdata[lvd_host_pkg::CMD_START_BIT];
	assign stop_cmd = i_wr && i_addr == lvd_host_pkg::HOST_CMD_ADDR &&
		i_wdata[lvd_host_pkg::CMD_STOP_BIT];
	assign cause_cmd = i_wr && i_addr == lvd_host_pkg::HOST_CMD_ADDR &&
		i_wdata[lvd_host_pkg::CMD_CAUSE_BIT];
	assign clear_present = cfg_reg[5:4] != lvd_host_pkg::CLEAR_OPT_NONE;
	assign level_ok = level_allowed(cfg_reg[5:4], level_reg);

	// Byte access each state makes; the level byte carries zeros above bit 2
	always_comb begin
		access_state = 1'b1;
		acc_we = 1'b1;
		acc_addr = lvd_host_pkg::DET_CONTROL_ADDR;
		acc_wdata = lvd_host_pkg::BYTE_ZERO;
		case (state_reg)
			lvd_host_pkg::ST_MASK: begin
				acc_addr = lvd_host_pkg::IRQ_MASK_LOW_ADDR;
				acc_wdata = lvd_host_pkg::MASK_SET;
			end
			lvd_host_pkg::ST_LEVEL: begin
				acc_addr = lvd_host_pkg::DET_LEVEL_ADDR;
				acc_wdata = {5'h00, level_reg};
			end
			lvd_host_pkg::ST_REF_ON: acc_wdata = lvd_host_pkg::CTRL_REF_ON;
			lvd_host_pkg::ST_DET_ON: acc_wdata = lvd_host_pkg::CTRL_DET_ON;
			lvd_host_pkg::ST_CHECK: acc_we = 1'b0;
			lvd_host_pkg::ST_SVC_READ: acc_we = 1'b0;
			lvd_host_pkg::ST_SET_MODE: acc_wdata = lvd_host_pkg::CTRL_RESET_MODE;
			lvd_host_pkg::ST_CLR_PEND: acc_addr = lvd_host_pkg::IRQ_REQUEST_LOW_ADDR;
			lvd_host_pkg::ST_SVC_CLR: acc_addr = lvd_host_pkg::IRQ_REQUEST_LOW_ADDR;
			lvd_host_pkg::ST_UNMASK: acc_addr = lvd_host_pkg::IRQ_MASK_LOW_ADDR;
			lvd_host_pkg::ST_STOP: acc_wdata = lvd_host_pkg::BYTE_ZERO;
			lvd_host_pkg::ST_CAUSE: begin
				acc_we = 1'b0;
				acc_addr = lvd_host_pkg::RESET_CAUSE_ADDR;
			end
			default: access_state = 1'b0;
		endcase
	end

	assign acc.req = access_state && !pending_reg && acc.ready;
	assign acc.we = acc_we;
	assign acc.addr = acc_addr;
	assign acc.wdata = acc_wdata;

	// Sequencer: start, stop, interrupt service and cause read-back
	always_comb begin
		state_next = state_reg;
		pending_next = pending_reg;
		cnt_next = cnt_reg;
		irq_en_next = irq_en_reg;
		refused_next = refused_reg;
		flag_next = flag_reg;
		mask_done_next = mask_done_reg;
		run_mode_next = run_mode_reg;
		cause_next = cause_reg;
		if (acc.req) begin
			pending_next = 1'b1;
		end
		if (acc.done) begin
			pending_next = 1'b0;
		end
		case (state_reg)
			lvd_host_pkg::ST_IDLE: begin
				if (start_cmd) begin
					if (level_ok) begin
						refused_next = 1'b0;
						mask_done_next = 1'b0;
						run_mode_next = cfg_reg[0];
						state_next = lvd_host_pkg::ST_MASK;
					end else begin
						refused_next = 1'b1;
					end
				end else if (cause_cmd) begin
					state_next = lvd_host_pkg::ST_CAUSE;
				end
			end
			// Mask first, so enabling detection cannot fire at once
			lvd_host_pkg::ST_MASK: if (acc.done) begin
				mask_done_next = 1'b1;
				state_next = lvd_host_pkg::ST_LEVEL;
			end
			lvd_host_pkg::ST_LEVEL: if (acc.done) begin
				if (clear_present) begin
					state_next = lvd_host_pkg::ST_DET_ON;
				end else begin
					state_next = lvd_host_pkg::ST_REF_ON;
				end
			end
			lvd_host_pkg::ST_REF_ON: if (acc.done) begin
				cnt_next = REF_LOAD;
				state_next = lvd_host_pkg::ST_REF_WAIT;
			end
			lvd_host_pkg::ST_REF_WAIT: begin
				cnt_next = cnt_reg - 1'b1;
				if (stop_cmd) begin
					state_next = lvd_host_pkg::ST_STOP;
				end else if (cnt_reg == '0) begin
					state_next = lvd_host_pkg::ST_DET_ON;
				end
			end
			lvd_host_pkg::ST_DET_ON: if (acc.done) begin
				cnt_next = DET_LOAD;
				state_next = lvd_host_pkg::ST_DET_WAIT;
			end
			lvd_host_pkg::ST_DET_WAIT: begin
				cnt_next = cnt_reg - 1'b1;
				if (stop_cmd) begin
					state_next = lvd_host_pkg::ST_STOP;
				end else if (cnt_reg == '0) begin
					state_next = lvd_host_pkg::ST_CHECK;
				end
			end
			// Go on only when the flag reports supply at or above threshold
			lvd_host_pkg::ST_CHECK: if (acc.done) begin
				flag_next = acc.rdata[lvd_host_pkg::BELOW_FLAG_BIT];
				if (acc.rdata[lvd_host_pkg::BELOW_FLAG_BIT]) begin
					cnt_next = DET_LOAD;
					state_next = lvd_host_pkg::ST_DET_WAIT;
				end else if (run_mode_reg) begin
					state_next = lvd_host_pkg::ST_SET_MODE;
				end else begin
					state_next = lvd_host_pkg::ST_CLR_PEND;
				end
			end
			lvd_host_pkg::ST_SET_MODE: if (acc.done) begin
				state_next = lvd_host_pkg::ST_RUN;
			end
			lvd_host_pkg::ST_CLR_PEND: if (acc.done) begin
				state_next = lvd_host_pkg::ST_UNMASK;
			end
			lvd_host_pkg::ST_UNMASK: if (acc.done) begin
				irq_en_next = 1'b1;
				state_next = lvd_host_pkg::ST_RUN;
			end
			lvd_host_pkg::ST_RUN: begin
				if (stop_cmd) begin
					irq_en_next = 1'b0;
					state_next = lvd_host_pkg::ST_STOP;
				end else if (!run_mode_reg && irq_en_reg && i_low_supply_irq) begin
					irq_en_next = 1'b0;
					state_next = lvd_host_pkg::ST_SVC_READ;
				end
			end
			// Handler waits out a low supply before clearing the request
			lvd_host_pkg::ST_SVC_READ: if (acc.done) begin
				flag_next = acc.rdata[lvd_host_pkg::BELOW_FLAG_BIT];
				if (acc.rdata[lvd_host_pkg::BELOW_FLAG_BIT]) begin
					cnt_next = DET_LOAD;
					state_next = lvd_host_pkg::ST_SVC_WAIT;
				end else begin
					state_next = lvd_host_pkg::ST_SVC_CLR;
				end
			end
			lvd_host_pkg::ST_SVC_WAIT: begin
				cnt_next = cnt_reg - 1'b1;
				if (stop_cmd) begin
					state_next = lvd_host_pkg::ST_STOP;
				end else if (cnt_reg == '0) begin
					state_next = lvd_host_pkg::ST_SVC_READ;
				end
			end
			lvd_host_pkg::ST_SVC_CLR: if (acc.done) begin
				irq_en_next = 1'b1;
				state_next = lvd_host_pkg::ST_RUN;
			end
			lvd_host_pkg::ST_STOP: if (acc.done) begin
				state_next = lvd_host_pkg::ST_IDLE;
			end
			lvd_host_pkg::ST_CAUSE: if (acc.done) begin
				cause_next = acc.rdata;
				state_next = lvd_host_pkg::ST_IDLE;
			end
			default: state_next = lvd_host_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state_reg <= lvd_host_pkg::ST_IDLE;
			pending_reg <= 1'b0;
			cnt_reg <= '0;
			irq_en_reg <= 1'b0;
			refused_reg <= 1'b0;
			flag_reg <= 1'b0;
			mask_done_reg <= 1'b0;
			run_mode_reg <= 1'b0;
			cause_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			pending_reg <= pending_next;
			cnt_reg <= cnt_next;
			irq_en_reg <= irq_en_next;
			refused_reg <= refused_next;
			flag_reg <= flag_next;
			mask_done_reg <= mask_done_next;
			run_mode_reg <= run_mode_next;
			cause_reg <= cause_next;
		end
	end

	// Command port; configuration is frozen while a sequence runs
	always_comb begin
		cfg_next = cfg_reg;
		level_next = level_reg;
		rdata_next = 8'h00;
		if (i_wr && state_reg == lvd_host_pkg::ST_IDLE) begin
			if (i_addr == lvd_host_pkg::HOST_CFG_ADDR) begin
				cfg_next = {2'h0, i_wdata[5:4], 3'h0, i_wdata[0]};
			end
			if (i_addr == lvd_host_pkg::HOST_LEVEL_ADDR) begin
				level_next = i_wdata[2:0];
			end
		end
		if (i_rd) begin
			case (i_addr)
				lvd_host_pkg::HOST_CFG_ADDR: rdata_next = cfg_reg;
				lvd_host_pkg::HOST_LEVEL_ADDR: rdata_next = {5'h00, level_reg};
				lvd_host_pkg::HOST_STATUS_ADDR: rdata_next = {3'h0, run_mode_reg, flag_reg,
					refused_reg, state_reg == lvd_host_pkg::ST_RUN, o_busy};
				lvd_host_pkg::HOST_CAUSE_ADDR: rdata_next = cause_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			cfg_reg <= lvd_host_pkg::CFG_RESET;
			level_reg <= lvd_host_pkg::LEVEL_RESET;
			rdata_reg <= 8'h00;
		end else begin
			cfg_reg <= cfg_next;
			level_reg <= level_next;
			rdata_reg <= rdata_next;
		end
	end

	assign o_rdata = rdata_reg;
	assign o_vectored_irq_enable = irq_en_reg;
	assign o_busy = state_reg != lvd_host_pkg::ST_IDLE && state_reg != lvd_host_pkg::ST_RUN;

	AST_LEVEL_HIGH_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_dev_wr && o_dev_addr == lvd_host_pkg::DET_LEVEL_ADDR |-> o_dev_wdata[7:3] == 5'h00)
		else $error("level byte written with upper bits set");
	AST_ONE_STROBE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_dev_wr |=> !o_dev_wr && !o_dev_rd)
		else $error("device strobe longer than one byte access");
	AST_CLEAR_HIGH_LEVEL: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_dev_wr && o_dev_addr == lvd_host_pkg::DET_LEVEL_ADDR &&
		cfg_reg[5:4] == lvd_host_pkg::CLEAR_OPT_HIGH |-> o_dev_wdata[2:0] < 3'h4)
		else $error("blocked level code sent with high power-on-clear");
	AST_CLEAR_LOW_LEVEL: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_dev_wr && o_dev_addr == lvd_host_pkg::DET_LEVEL_ADDR &&
		cfg_reg[5:4] == lvd_host_pkg::CLEAR_OPT_LOW |-> o_dev_wdata[2:0] != 3'h7)
		else $error("level code seven sent with low power-on-clear");
	AST_REF_WAIT_END: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		state_reg == lvd_host_pkg::ST_DET_ON && $past(state_reg) != lvd_host_pkg::ST_DET_ON
		|-> $past(state_reg) == lvd_host_pkg::ST_REF_WAIT && $past(cnt_reg) == '0 || clear_present)
		else $error("detection enabled before the reference wait ended");
	AST_MASK_BEFORE_ENABLE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_dev_wr && o_dev_addr == lvd_host_pkg::DET_CONTROL_ADDR &&
		o_dev_wdata[lvd_host_pkg::DETECT_ENABLE_BIT] |-> mask_done_reg)
		else $error("detection enabled before the mask was set");
	AST_STOP_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		state_reg == lvd_host_pkg::ST_STOP && o_dev_wr |-> o_dev_wdata == 8'h00 &&
		o_dev_addr == lvd_host_pkg::DET_CONTROL_ADDR)
		else $error("stop did not write a zero control byte");
	AST_UNMASK_ORDER: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		$rose(irq_en_reg) |-> $past(state_reg) == lvd_host_pkg::ST_UNMASK ||
		$past(state_reg) == lvd_host_pkg::ST_SVC_CLR)
		else $error("interrupts enabled out of order");
	AST_SVC_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		state_reg == lvd_host_pkg::ST_SVC_CLR && o_dev_wr |->
		!o_dev_wdata[lvd_host_pkg::IRQ_PENDING_BIT] && !irq_en_reg ##[1:3] irq_en_reg)
		else $error("handler did not clear pending and re-enable");
endmodule

// ===== testbench/dev_model.sv
`timescale 1ns/1ps
module dev_model (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic [15:0] i_dev_addr,
	input wire logic [7:0] i_dev_wdata,
	input wire logic i_dev_wr,
	input wire logic i_dev_rd,
	input wire logic i_supply_low,
	output logic [7:0] o_dev_rdata,
	output logic o_low_supply_irq
);
	logic [7:0] level_reg;
	logic [7:0] ctrl_reg;
	logic mask_reg;
	logic pend_reg;
	logic cause_reg;
	logic [1:0] sync_reg;
	logic flag;
	logic [7:0] rd_val;
	logic [23:0] wlog [$];
	int cyc = 0;
	int ref_at = 0;
	int det_at = 0;
	int ref_gap = 0;
	int det_gap = 0;
	// Flag only reads high while detection runs
	assign flag = sync_reg[1] & ctrl_reg[7];
	assign o_low_supply_irq = pend_reg & ~mask_reg;
	// Read mux; the low-supply bits all sit at bit zero
	always_comb begin
		case (i_dev_addr)
			lvd_host_pkg::DET_CONTROL_ADDR: rd_val = {ctrl_reg[7:1], flag};
			lvd_host_pkg::DET_LEVEL_ADDR: rd_val = level_reg;
			lvd_host_pkg::IRQ_REQUEST_LOW_ADDR: rd_val = {7'h00, pend_reg};
			lvd_host_pkg::IRQ_MASK_LOW_ADDR: rd_val = {7'h00, mask_reg};
			lvd_host_pkg::RESET_CAUSE_ADDR: rd_val = {7'h00, cause_reg};
			default: rd_val = 8'h00;
		endcase
	end
	// Read data stand one cycle only, then the bus shows the inverse
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		sync_reg <= {sync_reg[0], i_supply_low};
		o_dev_rdata <= i_dev_rd ? rd_val : ~o_dev_rdata;
		if (i_reset) begin
			level_reg <= 8'h00;
			ctrl_reg <= 8'h00;
			mask_reg <= 1'b1;
			pend_reg <= 1'b0;
			cause_reg <= 1'b0;
			o_dev_rdata <= 8'hA5;
		end else begin
			if (flag & ~ctrl_reg[1]) begin
				pend_reg <= 1'b1;
			end
			// Detector reset keeps the control bits, unlike a chip reset
			if (flag & ctrl_reg[1]) begin
				cause_reg <= 1'b1;
				level_reg <= 8'h00;
				mask_reg <= 1'b1;
				pend_reg <= 1'b0;
			end
			if (i_dev_rd && i_dev_addr == lvd_host_pkg::DET_CONTROL_ADDR) begin
				det_gap <= cyc - det_at;
			end
			if (i_dev_wr) begin
				wlog.push_back({i_dev_addr, i_dev_wdata});
				case (i_dev_addr)
					lvd_host_pkg::DET_CONTROL_ADDR: begin
						ctrl_reg <= i_dev_wdata & 8'h92;
						if (i_dev_wdata[7] & ~ctrl_reg[7]) begin
							ref_gap <= cyc - ref_at;
							det_at <= cyc;
						end else if (i_dev_wdata[4]) begin
							ref_at <= cyc;
						end
					end
					lvd_host_pkg::DET_LEVEL_ADDR: level_reg <= i_dev_wdata;
					lvd_host_pkg::IRQ_REQUEST_LOW_ADDR: pend_reg <= i_dev_wdata[0];
					lvd_host_pkg::IRQ_MASK_LOW_ADDR: mask_reg <= i_dev_wdata[0];
					default: ;
				endcase
			end
		end
	end
endmodule

// ===== testbench/low_voltage_detect_control_tb.sv
`timescale 1ns/1ps
module low_voltage_detect_control_tb;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic supply_low = 1'b0;
	logic [7:0] rdata;
	logic [15:0] dev_addr;
	logic [7:0] dev_wdata;
	logic dev_wr;
	logic dev_rd;
	logic [7:0] dev_rdata;
	logic low_irq;
	logic irq_en;
	logic busy;
	logic [7:0] val;
	logic [7:0] bad_cfg [3] = '{8'h20, 8'h20, 8'h10};
	logic [7:0] bad_lvl [3] = '{8'h04, 8'h07, 8'h07};
	logic [23:0] exp_log [$];
	int failures = 0;
	int n_checks = 0;

	low_voltage_detect_control #(.REF_WAIT_CYCLES(20), .DET_WAIT_CYCLES(8))
		low_voltage_detect_control_inst (.i_sys_clk(sys_clk), .i_reset(reset),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.o_dev_addr(dev_addr), .o_dev_wdata(dev_wdata), .o_dev_wr(dev_wr),
		.o_dev_rd(dev_rd), .i_dev_rdata(dev_rdata), .i_low_supply_irq(low_irq),
		.o_vectored_irq_enable(irq_en), .o_busy(busy));
	dev_model dev_model_inst (.i_sys_clk(sys_clk), .i_reset(reset), .i_dev_addr(dev_addr),
		.i_dev_wdata(dev_wdata), .i_dev_wr(dev_wr), .i_dev_rd(dev_rd),
		.i_supply_low(supply_low), .o_dev_rdata(dev_rdata), .o_low_supply_irq(low_irq));

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic close_out();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cmd_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic cmd_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// Bounded wait for a level; running out ends the run
	task automatic wait_lvl(ref logic s, input logic v, input int n);
		int i;
		repeat (3) @(posedge sys_clk);
		#1;
		for (i = 0; i < n && s !== v; i++) begin
			@(posedge sys_clk);
			#1;
		end
		if (s !== v) begin
			chk("wait bound", 24'h0, 24'h1);
			close_out();
		end
	endtask
	// Device write order compared entry by entry, then both lists cleared
	task automatic chk_log();
		int i;
		chk("log size", exp_log.size(), dev_model_inst.wlog.size());
		for (i = 0; i < exp_log.size() && i < dev_model_inst.wlog.size(); i++) begin
			chk("device write", exp_log[i], dev_model_inst.wlog[i]);
		end
		exp_log.delete();
		dev_model_inst.wlog.delete();
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("outputs", 24'h0, {dev_wr, dev_rd, irq_en, busy});
		chk("level", 24'h00, dev_model_inst.level_reg);
		chk("mask", 24'h1, dev_model_inst.mask_reg);
		chk("control", 24'h00, dev_model_inst.ctrl_reg);
		cmd_rd(lvd_host_pkg::HOST_CFG_ADDR, val);
		chk("cfg", lvd_host_pkg::CFG_RESET, val);
		cmd_rd(4'hF, val);
		chk("unmapped", 24'h00, val);
		// Forbidden codes must leave the device untouched
		for (int i = 0; i < 3; i++) begin
			cmd_wr(lvd_host_pkg::HOST_CFG_ADDR, bad_cfg[i]);
			cmd_wr(lvd_host_pkg::HOST_LEVEL_ADDR, bad_lvl[i]);
			cmd_wr(lvd_host_pkg::HOST_CMD_ADDR, 8'h01);
			wait_lvl(busy, 1'b0, 100);
			cmd_rd(lvd_host_pkg::HOST_STATUS_ADDR, val);
			chk("refused", 24'h1, val[2]);
			chk_log();
		end
		// Interrupt mode; upper level bits must be dropped on the way out
		cmd_wr(lvd_host_pkg::HOST_CFG_ADDR, 8'h00);
		cmd_wr(lvd_host_pkg::HOST_LEVEL_ADDR, 8'hFB);
		cmd_wr(lvd_host_pkg::HOST_CMD_ADDR, 8'h01);
		wait_lvl(busy, 1'b0, 400);
		exp_log = '{24'hFFE401, 24'hFFBF03, 24'hFFBE10, 24'hFFBE90, 24'hFFE000, 24'hFFE400};
		chk_log();
		chk("ref wait", 24'h1, dev_model_inst.ref_gap >= 20);
		chk("det wait", 24'h1, dev_model_inst.det_gap >= 8);
		chk("irq enable", 24'h1, irq_en);
		cmd_rd(lvd_host_pkg::HOST_STATUS_ADDR, val);
		chk("status irq run", 24'h02, val);
		// Low supply: handler waits for recovery, then clears pending
		supply_low <= 1'b1;
		wait_lvl(irq_en, 1'b0, 50);
		repeat (40) @(posedge sys_clk);
		supply_low <= 1'b0;
		wait_lvl(irq_en, 1'b1, 200);
		chk("pending", 24'h0, dev_model_inst.pend_reg);
		exp_log = '{24'hFFE000};
		chk_log();
		cmd_wr(lvd_host_pkg::HOST_CMD_ADDR, 8'h02);
		wait_lvl(busy, 1'b0, 100);
		exp_log = '{24'hFFBE00};
		chk_log();
		// Reset mode, low power-on-clear, highest legal code
		cmd_wr(lvd_host_pkg::HOST_CFG_ADDR, 8'h11);
		cmd_wr(lvd_host_pkg::HOST_LEVEL_ADDR, 8'h06);
		cmd_wr(lvd_host_pkg::HOST_CMD_ADDR, 8'h01);
		wait_lvl(busy, 1'b0, 400);
		exp_log = '{24'hFFE401, 24'hFFBF06, 24'hFFBE90, 24'hFFBE92};
		chk_log();
		chk("no cause", 24'h0, dev_model_inst.cause_reg);
		cmd_rd(lvd_host_pkg::HOST_STATUS_ADDR, val);
		chk("status reset run", 24'h12, val);
		supply_low <= 1'b1;
		repeat (6) @(posedge sys_clk);
		supply_low <= 1'b0;
		#1;
		chk("cause", 24'h1, dev_model_inst.cause_reg);
		chk("kept", 24'h92, dev_model_inst.ctrl_reg);
		repeat (6) @(posedge sys_clk);
		cmd_wr(lvd_host_pkg::HOST_CMD_ADDR, 8'h02);
		wait_lvl(busy, 1'b0, 100);
		exp_log = '{24'hFFBE00};
		chk_log();
		cmd_wr(lvd_host_pkg::HOST_CMD_ADDR, 8'h08);
		wait_lvl(busy, 1'b0, 100);
		cmd_rd(lvd_host_pkg::HOST_CAUSE_ADDR, val);
		chk("cause byte", 24'h01, val);
		// Stop lands inside the reference wait; detection must never be enabled
		cmd_wr(lvd_host_pkg::HOST_CFG_ADDR, 8'h00);
		cmd_wr(lvd_host_pkg::HOST_LEVEL_ADDR, 8'h02);
		cmd_wr(lvd_host_pkg::HOST_CMD_ADDR, 8'h01);
		repeat (16) @(posedge sys_clk);
		cmd_wr(lvd_host_pkg::HOST_CMD_ADDR, 8'h02);
		wait_lvl(busy, 1'b0, 100);
		exp_log = '{24'hFFE401, 24'hFFBF02, 24'hFFBE10, 24'hFFBE00};
		chk_log();
		close_out();
	end
endmodule
